// ===== core/reset_and_stop_recovery.sv
// Overview of operation
// - Stay in reset while pin low.
// - Pin held past timeout: exit 16 cycles later.
// - Early release: device drives pin until timeout.
// - Stop mode bypasses reset input filter.
// - External reset sets external reset flag.
// - Pin is open-drain reset indicator during reset.
// - Internal event drives pin low for delay.
// - Writing bit 0 starts system reset.
// - Debugger-written user reset spares debugger logic.
// - Fault detect forces reset, then sets flag.
// - Stop recovery holds reset 66 oscillator cycles.
// - Stop recovery keeps all other state.
// - Fetch vector from 0004h-0007h into PC.
// - Stop recovery sets stop flag.
// - Watchdog in stop: recovery, watchdog and stop flags.
// - Watchdog exception served after recovery completes.
// - Enabled GPIO edge starts recovery, sets stop.
// - Short GPIO pulse wakes without pin interrupt.
`timescale 1ns/1ps
module reset_and_stop_recovery #(
    parameter int GPIO_N = 8,
    parameter int FILTER_CYCLES = 4,
    parameter logic [15:0] SYS_TIMEOUT_CYCLES = 16'h0400,
    parameter logic [15:0] INT_DELAY_CYCLES = 16'h0100
) (
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Open-drain reset pin
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    // Register port
    input wire rst_rec_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Internal reset and wake sources
    input wire rst_rec_pkg::reset_src_t src,
    input wire logic stop_mode,
    input wire logic osc_tick,
    input wire logic [GPIO_N-1:0] gpio_pin,
    input wire logic [GPIO_N-1:0] gpio_wake_en,
    // Reset outputs
    output logic core_reset_b,
    output logic periph_reset_b,
    output logic debug_reset_b,
    output logic osc_ctrl_reset,
    // Reset vector fetch
    output rst_rec_pkg::vec_req_t vec_req,
    input wire logic [7:0] vec_data,
    output logic [31:0] pc_value,
    output logic pc_load,
    output logic watchdog_exc_req,
    // Interrupt
    output logic irq
);
    import rst_rec_pkg::*;

    // ****************************************************************
    // Pin synchronisers and reset input filter
    // ****************************************************************
    logic pin_s1_r, pin_s2_r;
    logic [GPIO_N-1:0] gpio_s1_r, gpio_s2_r, gpio_snap_r;
    logic [7:0] filt_cnt_r;
    logic pin_filt_r;
    logic pin_low;

    // Two flops ahead of any logic on the pins.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            gpio_s1_r <= '0;
            gpio_s2_r <= '0;
        end else begin
            pin_s1_r <= rst_pin_in;
            pin_s2_r <= pin_s1_r;
            gpio_s1_r <= gpio_pin;
            gpio_s2_r <= gpio_s1_r;
        end
    end

    // The filtered level follows the pin after it is stable long enough.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            filt_cnt_r <= 8'h00;
            pin_filt_r <= 1'b1;
        end else if (pin_s2_r == pin_filt_r) begin
            filt_cnt_r <= 8'h00;
        end else if (filt_cnt_r == 8'(FILTER_CYCLES - 1)) begin
            filt_cnt_r <= 8'h00;
            pin_filt_r <= pin_s2_r;
        end else begin
            filt_cnt_r <= filt_cnt_r + 8'h01;
        end
    end

    assign pin_low = stop_mode ? !pin_s2_r : !pin_filt_r;

    // ****************************************************************
    // Wake detection
    // ****************************************************************
    logic gpio_wake;

    // The pin levels are captured while running and during any reset sequence;
    // any enabled pin that differs in stop mode wakes the block, so a pulse
    // shorter than the interrupt path can see still leads to recovery. The
    // capture during recovery keeps the same change from waking it twice.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gpio_snap_r <= '0;
        end else if (!stop_mode || !core_reset_b) begin
            gpio_snap_r <= gpio_s2_r;
        end
    end

    assign gpio_wake = stop_mode && |((gpio_s2_r ^ gpio_snap_r) & gpio_wake_en);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    seq_state_t state_r;
    logic [15:0] cnt_r;
    logic [15:0] hold_len_r;
    logic drive_r;
    logic ext_cause_r, dbg_cause_r, fault_cause_r, wdt_cause_r, stop_cause_r;
    logic exc_mode_r;
    logic user_wr;
    logic int_event;
    logic fetch_done;

    assign user_wr = reg_req.wr && reg_req.addr == OFS_RESET_STATUS_CONTROL
        && reg_req.wdata[BIT_USER_RESET];
    assign int_event = src.fault_detect || src.voltage_brownout
        || (src.watchdog_unit_timeout && !stop_mode) || user_wr;
    assign fetch_done = state_r == ST_FETCH && cnt_r == VECTOR_BYTES;

    // State, counter and pin drive move together.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_HOLD;
            cnt_r <= 16'h0000;
            hold_len_r <= INT_DELAY_CYCLES;
            drive_r <= 1'b1;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    cnt_r <= 16'h0000;
                    if (pin_low) begin
                        state_r <= ST_HOLD;
                        hold_len_r <= SYS_TIMEOUT_CYCLES;
                        drive_r <= 1'b0;
                    end else if (int_event) begin
                        state_r <= ST_HOLD;
                        hold_len_r <= INT_DELAY_CYCLES;
                        drive_r <= 1'b1;
                    end else if (stop_mode && (src.watchdog_unit_timeout || gpio_wake)) begin
                        state_r <= ST_RECOVER;
                    end
                end
                ST_HOLD: begin
                    if (!pin_low) begin
                        drive_r <= 1'b1;
                    end
                    if (cnt_r >= hold_len_r - 16'h0001) begin
                        state_r <= ST_TAIL;
                        cnt_r <= 16'h0000;
                        drive_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_TAIL: begin
                    if (pin_low) begin
                        cnt_r <= 16'h0000;
                    end else if (cnt_r == TAIL_CYCLES - 16'h0001) begin
                        state_r <= ST_FETCH;
                        cnt_r <= 16'h0000;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_RECOVER: begin
                    if (osc_tick) begin
                        if (cnt_r == RECOVERY_OSC_CYCLES - 16'h0001) begin
                            state_r <= ST_FETCH;
                            cnt_r <= 16'h0000;
                        end else begin
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end
                end
                ST_FETCH: begin
                    if (fetch_done) begin
                        state_r <= ST_RUN;
                        cnt_r <= 16'h0000;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: begin
                    state_r <= ST_HOLD;
                    cnt_r <= 16'h0000;
                    hold_len_r <= INT_DELAY_CYCLES;
                    drive_r <= 1'b1;
                end
            endcase
        end
    end

    // Causes are latched on entry and cleared when the sequence ends.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_cause_r <= 1'b0;
            dbg_cause_r <= 1'b0;
            fault_cause_r <= 1'b0;
            wdt_cause_r <= 1'b0;
            stop_cause_r <= 1'b0;
            exc_mode_r <= 1'b0;
        end else if (state_r == ST_RUN) begin
            ext_cause_r <= pin_low;
            dbg_cause_r <= !pin_low && user_wr && src.write_from_on_chip_debugger;
            fault_cause_r <= !pin_low && src.fault_detect;
            wdt_cause_r <= !pin_low && src.watchdog_unit_timeout;
            stop_cause_r <= !pin_low && !int_event && stop_mode
                && (src.watchdog_unit_timeout || gpio_wake);
            exc_mode_r <= src.watchdog_unit_exc_mode;
        end
    end

    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = drive_r;

    assign core_reset_b = state_r == ST_RUN;
    assign periph_reset_b = !(state_r == ST_HOLD || state_r == ST_TAIL);
    assign debug_reset_b = periph_reset_b || dbg_cause_r;
    assign osc_ctrl_reset = state_r == ST_RECOVER;

    // ****************************************************************
    // Reset vector fetch
    // ****************************************************************
    // vector fetch
    assign vec_req.rd = state_r == ST_FETCH && cnt_r < VECTOR_BYTES;
    assign vec_req.addr = VECTOR_BASE + cnt_r;

    // Bytes return one cycle after each read and fill the PC high first.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pc_value <= 32'h00000000;
            pc_load <= 1'b0;
            watchdog_exc_req <= 1'b0;
        end else begin
            if (state_r == ST_FETCH && cnt_r != 16'h0000) begin
                pc_value <= {pc_value[23:0], vec_data};
            end
            pc_load <= fetch_done;
            watchdog_exc_req <= fetch_done && stop_cause_r && wdt_cause_r && exc_mode_r;
        end
    end

    // ****************************************************************
    // Registers and interrupt
    // ****************************************************************
    logic [7:0] rsc_r;
    logic [2:0] irq_stat_r, irq_mask_r, irq_set;
    logic rd_stat;

    // Flags are set when the sequence ends; write one clears, set wins.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rsc_r <= RSC_RESET;
        end else begin
            if (reg_req.wr && reg_req.addr == OFS_RESET_STATUS_CONTROL) begin
                rsc_r <= rsc_r & ~{reg_req.wdata[7:1], 1'b0};
            end
            if (fetch_done) begin
                if (ext_cause_r) rsc_r[BIT_EXTERNAL_RESET_FLAG] <= 1'b1;
                if (fault_cause_r) rsc_r[BIT_FAULT_DETECT_FLAG] <= 1'b1;
                if (wdt_cause_r) rsc_r[BIT_WATCHDOG_FLAG] <= 1'b1;
                if (stop_cause_r) rsc_r[BIT_STOP_FLAG] <= 1'b1;
            end
        end
    end

    assign irq_set = {watchdog_exc_req, fetch_done && stop_cause_r,
        fetch_done && !stop_cause_r};
    assign rd_stat = reg_req.rd && reg_req.addr == OFS_IRQ_STATUS;

    // Sticky events, cleared by a read of the status register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= IRQ_RESET;
        end else begin
            irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | irq_set;
        end
    end

    // Mask register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_r <= IRQ_RESET;
        end else if (reg_req.wr && reg_req.addr == OFS_IRQ_MASK) begin
            irq_mask_r <= reg_req.wdata[2:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // Read data stands one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_RESET_STATUS_CONTROL: reg_rdata <= {rsc_r[7:1], 1'b0};
                OFS_IRQ_STATUS: reg_rdata <= {5'h00, irq_stat_r};
                OFS_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_r};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ===== core/rst_rec_pkg.sv
package rst_rec_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OFS_RESET_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h01;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h02;

    // Reset status and control fields.
    localparam int BIT_USER_RESET = 0;
    localparam int BIT_EXTERNAL_RESET_FLAG = 4;
    localparam int BIT_WATCHDOG_FLAG = 5;
    localparam int BIT_STOP_FLAG = 6;
    localparam int BIT_FAULT_DETECT_FLAG = 7;
    localparam logic [7:0] RSC_RESET = 8'h00;

    // Interrupt status and mask fields.
    localparam int IRQ_RESET_DONE = 0;
    localparam int IRQ_RECOVERY_DONE = 1;
    localparam int IRQ_WATCHDOG_EXC = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ****************************************************************
    // Timing counts and reset vector location
    // ****************************************************************
    localparam logic [15:0] TAIL_CYCLES = 16'h0010;
    localparam logic [15:0] RECOVERY_OSC_CYCLES = 16'h0042;
    localparam logic [15:0] VECTOR_BASE = 16'h0004;
    localparam logic [15:0] VECTOR_BYTES = 16'h0004;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic fault_detect;
        logic voltage_brownout;
        logic watchdog_unit_timeout;
        logic watchdog_unit_exc_mode;
        logic write_from_on_chip_debugger;
    } reset_src_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
    } vec_req_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_HOLD = 5'b00010,
        ST_TAIL = 5'b00100,
        ST_RECOVER = 5'b01000,
        ST_FETCH = 5'b10000
    } seq_state_t;

endpackage

// ===== dv/rst_rec_monitor.sv
`timescale 1ns/1ps
module rst_rec_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Reset pin
    input wire logic rst_pin_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    // Register port
    input wire rst_rec_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Sequencer ports
    input wire logic osc_tick,
    input wire logic core_reset_b,
    input wire logic periph_reset_b,
    input wire logic osc_ctrl_reset,
    input wire rst_rec_pkg::vec_req_t vec_req,
    input wire logic pc_load,
    input wire logic watchdog_exc_req
);
    import rst_rec_pkg::*;
    // ********************
    // Helper counters
    // ********************
    logic [7:0] tick_cnt;
    logic [7:0] high_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Counts oscillator ticks in recovery and cycles of a high pin.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 8'h00;
            high_cnt <= 8'h00;
        end else begin
            tick_cnt <= !osc_ctrl_reset ? 8'h00 : tick_cnt + {7'h00, osc_tick};
            high_cnt <= !rst_pin_in ? 8'h00 : high_cnt + {7'h00, high_cnt != 8'hff};
        end
    end
    // ********************
    // Properties
    // ********************
    sequence s_fetch;
        vec_req.rd && vec_req.addr == 16'h0004 ##1 vec_req.rd && vec_req.addr == 16'h0005
        ##1 vec_req.rd && vec_req.addr == 16'h0006 ##1 vec_req.rd && vec_req.addr == 16'h0007;
    endsequence
    property p_pin_hold;
        !rst_pin_in [*8] |=> !core_reset_b;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("core left reset with pin low");
    property p_tail;
        $rose(periph_reset_b) |-> high_cnt >= 8'h10 && high_cnt <= 8'h28;
    endproperty
    a_tail: assert property (p_tail) else $error("reset tail length wrong");
    property p_pin_drive;
        rst_pin_oe |-> !rst_pin_out && !core_reset_b;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin driven outside reset");
    property p_osc;
        $fell(osc_ctrl_reset) |-> tick_cnt == 8'h42;
    endproperty
    a_osc: assert property (p_osc) else $error("recovery tick count wrong");
    property p_rec_scope;
        osc_ctrl_reset |-> !core_reset_b && periph_reset_b;
    endproperty
    a_rec_scope: assert property (p_rec_scope) else $error("recovery reset scope wrong");
    property p_fetch;
        $rose(vec_req.rd) |-> s_fetch ##[1:2] pc_load ##[0:1] core_reset_b;
    endproperty
    a_fetch: assert property (p_fetch) else $error("vector fetch order wrong");
    property p_exc;
        watchdog_exc_req |-> pc_load;
    endproperty
    a_exc: assert property (p_exc) else $error("exception request off load");
    property p_rdata;
        !$past(reg_req.rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule

// ===== dv/reset_line_partner.sv
`timescale 1ns/1ps
module reset_line_partner (
    // Other parties on the line
    input wire logic ext_low,
    // Device side of the pin
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    // Resolved level
    output logic rst_pin_in
);
    // Pull-up holds the line high unless some party pulls it low.
    assign rst_pin_in = !(ext_low || (rst_pin_oe && !rst_pin_out));
endmodule

// ===== dv/reset_and_stop_recovery_tb_top.sv
`timescale 1ns/1ps
module reset_and_stop_recovery_tb_top;
    import rst_rec_pkg::*;
    // ********************
    // Bench signals
    // ********************
    logic clk_sys, rst_b, ext_low, stop_mode, osc_tick, rst_pin_in, rst_pin_out, rst_pin_oe;
    logic core_reset_b, periph_reset_b, debug_reset_b, osc_ctrl_reset, pc_load, irq, exc_seen;
    logic watchdog_exc_req;
    logic [1:0] tick_div;
    logic [7:0] gpio_pin, gpio_wake_en, reg_rdata, vec_data;
    logic [31:0] pc_value;
    reg_req_t reg_req;
    reset_src_t src;
    vec_req_t vec_req;
    int fails, n_tests;
    // Clock of 5 ns period.
    always #2.5 clk_sys = ~clk_sys;
    // Oscillator tick on every fourth cycle.
    always @(posedge clk_sys) begin
        tick_div <= tick_div + 2'h1;
        osc_tick <= (tick_div == 2'h3);
    end
    // Program memory returns each vector byte one cycle later.
    always @(posedge clk_sys) begin
        vec_data <= vec_req.addr[7:0] ^ 8'ha0;
    end
    reset_line_partner u_reset_line_partner (.ext_low(ext_low), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .rst_pin_in(rst_pin_in));
    reset_and_stop_recovery #(.SYS_TIMEOUT_CYCLES(16'h0010), .INT_DELAY_CYCLES(16'h0004))
    u_reset_and_stop_recovery (.clk_sys(clk_sys), .rst_b(rst_b), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .src(src), .stop_mode(stop_mode), .osc_tick(osc_tick),
        .gpio_pin(gpio_pin), .gpio_wake_en(gpio_wake_en), .core_reset_b(core_reset_b),
        .periph_reset_b(periph_reset_b), .debug_reset_b(debug_reset_b),
        .osc_ctrl_reset(osc_ctrl_reset), .vec_req(vec_req), .vec_data(vec_data),
        .pc_value(pc_value), .pc_load(pc_load), .watchdog_exc_req(watchdog_exc_req), .irq(irq));
    // ********************
    // Tasks
    // ********************
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1;
        chk(nm, {24'h0, exp}, {24'h0, reg_rdata});
    endtask
    // Waits for the vector load, then checks the loaded address.
    task wait_load;
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk_sys);
            #1;
            if (pc_load === 1'b1) break;
        end
        exc_seen = watchdog_exc_req;
        if (i == 3000) begin
            fails++;
            give_verdict();
        end
        chk("pc", 32'ha4a5a6a7, pc_value);
        cyc(2);
    endtask
    task s_power;
        wait_load();
        rd(OFS_RESET_STATUS_CONTROL, 8'h00, "flags");
        rd(OFS_IRQ_STATUS, 8'h01, "irq status");
        rd(OFS_IRQ_STATUS, 8'h00, "irq status");
        wr(8'h3f, 8'hff);
        rd(8'h3f, 8'h00, "unmapped");
        chk("irq", 0, irq);
    endtask
    task s_ext(input int len, input logic early);
        int i;
        @(posedge clk_sys);
        ext_low <= 1'b1;
        cyc(len);
        #1;
        chk("core reset", 0, core_reset_b);
        @(posedge clk_sys);
        ext_low <= 1'b0;
        for (i = 0; early && i < 12 && rst_pin_oe !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (early) chk("pin drive", 1, rst_pin_oe);
        wait_load();
        rd(OFS_RESET_STATUS_CONTROL, 8'h10, "ext flag");
        rd(OFS_IRQ_STATUS, 8'h01, "irq status");
        wr(OFS_RESET_STATUS_CONTROL, 8'h10);
        rd(OFS_RESET_STATUS_CONTROL, 8'h00, "flags");
    endtask
    task s_evt(input reset_src_t m, input logic [7:0] flag);
        @(posedge clk_sys);
        src <= reset_src_t'(src | m);
        @(posedge clk_sys);
        src <= reset_src_t'(src & ~m);
        cyc(1);
        #1;
        chk("pin drive", 1, rst_pin_oe);
        wait_load();
        rd(OFS_RESET_STATUS_CONTROL, flag, "flags");
        rd(OFS_IRQ_STATUS, 8'h01, "irq status");
        wr(OFS_RESET_STATUS_CONTROL, 8'hf0);
    endtask
    task s_user(input logic dbg);
        @(posedge clk_sys);
        src.write_from_on_chip_debugger <= dbg;
        wr(OFS_RESET_STATUS_CONTROL, 8'h01);
        #1;
        chk("core reset", 0, core_reset_b);
        chk("debug reset", dbg, debug_reset_b);
        wait_load();
        src.write_from_on_chip_debugger <= 1'b0;
        rd(OFS_RESET_STATUS_CONTROL, 8'h00, "flags");
        rd(OFS_IRQ_STATUS, 8'h01, "irq status");
    endtask
    task s_stop(input logic wdog);
        wr(OFS_IRQ_MASK, 8'h06);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        gpio_wake_en <= 8'h01;
        cyc(4);
        gpio_pin <= gpio_pin ^ 8'h02;
        cyc(8);
        #1;
        chk("core reset", 1, core_reset_b);
        @(posedge clk_sys);
        if (wdog) src <= reset_src_t'(5'h06);
        else gpio_pin <= gpio_pin ^ 8'h01;
        @(posedge clk_sys);
        src <= reset_src_t'({4'h0, wdog} << 1);
        cyc(8);
        #1;
        chk("osc reset", 1, osc_ctrl_reset);
        chk("periph reset", 1, periph_reset_b);
        wait_load();
        stop_mode <= 1'b0;
        chk("exc", wdog, exc_seen);
        chk("irq", 1, irq);
        rd(OFS_RESET_STATUS_CONTROL, wdog ? 8'h60 : 8'h40, "flags");
        rd(OFS_IRQ_STATUS, wdog ? 8'h06 : 8'h02, "irq status");
        cyc(1);
        #1;
        chk("irq", 0, irq);
        wr(OFS_RESET_STATUS_CONTROL, 8'hf0);
        src <= '0;
    endtask
    // A pin pulse shorter than the filter resets the block only in stop mode.
    task s_glitch(input logic stp);
        @(posedge clk_sys);
        stop_mode <= stp;
        ext_low <= 1'b1;
        cyc(3);
        ext_low <= 1'b0;
        cyc(6);
        #1;
        chk("core reset", {31'h0, !stp}, core_reset_b);
        if (stp) begin
            wait_load();
            stop_mode <= 1'b0;
            rd(OFS_RESET_STATUS_CONTROL, 8'h10, "ext flag");
            wr(OFS_RESET_STATUS_CONTROL, 8'h10);
        end
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        {ext_low, stop_mode, osc_tick, tick_div, exc_seen} = '0;
        {gpio_pin, gpio_wake_en} = '0;
        src = '0;
        reg_req = '0;
        fails = 0;
        n_tests = 0;
        cyc(2);
        rst_b <= 1'b1;
        s_power();
        s_ext(40, 1'b0);
        s_ext(9, 1'b1);
        s_evt(reset_src_t'(5'h10), 8'h80);
        s_evt(reset_src_t'(5'h08), 8'h00);
        s_evt(reset_src_t'(5'h04), 8'h20);
        s_user(1'b0);
        s_user(1'b1);
        s_stop(1'b1);
        s_stop(1'b0);
        s_glitch(1'b0);
        s_glitch(1'b1);
        give_verdict();
    end
endmodule
bind reset_and_stop_recovery rst_rec_monitor u_rst_rec_monitor (.clk_sys(clk_sys),
    .rst_b(rst_b), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .reg_req(reg_req), .reg_rdata(reg_rdata), .osc_tick(osc_tick),
    .core_reset_b(core_reset_b), .periph_reset_b(periph_reset_b),
    .osc_ctrl_reset(osc_ctrl_reset), .vec_req(vec_req), .pc_load(pc_load),
    .watchdog_exc_req(watchdog_exc_req));
